// File: rxmf_consts.vh
`ifndef RXMF_CONSTS_VH
`define RXMF_CONSTS_VH

// Short-range register addresses.
`define RXMF_ADDR_RX_MAC_CTRL 6'h00
`define RXMF_ADDR_FILTER_FLUSH 6'h0d
`define RXMF_ADDR_SOFT_RESET 6'h2a
`define RXMF_ADDR_INT_STATUS 6'h31
`define RXMF_ADDR_INT_ENABLE 6'h32
`define RXMF_ADDR_BB_CTRL_ONE 6'h39

// Receive buffer window in the long address range.
`define RXMF_BUF_FIRST 10'h300
`define RXMF_BUF_LAST 10'h38f

// Field positions.
`define RXMF_MODE_LSB 0
`define RXMF_PAN_COORD_BIT 3
`define RXMF_NO_ACK_BIT 5
`define RXMF_FLUSH_BIT 0
`define RXMF_FILTER_LSB 1
`define RXMF_SOFT_MAC_BIT 0
`define RXMF_RX_IRQ_BIT 3
`define RXMF_SEC_IRQ_BIT 4
`define RXMF_DECINV_BIT 2
`define RXMF_FCF_SEC_BIT 3
`define RXMF_FCF_ACKREQ_BIT 5
`define RXMF_FCF_PANCOMP_BIT 6

// Writable bit masks of the stored registers.
`define RXMF_MASK_RX_MAC_CTRL 8'h2f
`define RXMF_MASK_FILTER_FLUSH 8'h6e
`define RXMF_MASK_BB_CTRL_ONE 8'h04

// Reset values.
`define RXMF_RST_RX_MAC_CTRL 8'h00
`define RXMF_RST_FILTER_FLUSH 8'h00
`define RXMF_RST_INT_ENABLE 8'h00
`define RXMF_RST_BB_CTRL_ONE 8'h00

// Reception modes and frame-type filter codes.
`define RXMF_MODE_NORMAL 2'h0
`define RXMF_MODE_PROMISC 2'h1
`define RXMF_MODE_ERROR 2'h2
`define RXMF_FILT_ALL 3'h0
`define RXMF_FILT_CMD 3'h4
`define RXMF_FILT_DATA 3'h2
`define RXMF_FILT_BEACON 3'h1

// Frame types and broadcast identifier.
`define RXMF_TYPE_BEACON 3'h0
`define RXMF_TYPE_DATA 3'h1
`define RXMF_TYPE_CMD 3'h3
`define RXMF_BROADCAST 16'hffff

// Frame check sequence, reflected polynomial, zero residue over data and FCS.
`define RXMF_CRC_POLY 16'h8408

// Serial port framing: header bits of short and long accesses.
`define RXMF_SHORT_HDR 5'h08
`define RXMF_LONG_HDR 5'h10

`endif

// File: rxmf_buffer.v
`timescale 1ns/1ps
module rxmf_buffer
#(
   parameter AW = 8,
   parameter DW = 8
)
(
   input wire clk,               // Device clock.
   input wire wrEn,              // Write strobe from the receive side.
   input wire [AW-1:0] wrAddr,   // Write address.
   input wire [DW-1:0] wrData,   // Write data.
   input wire [AW-1:0] rdAddr,   // Read address from the host side.
   output reg [DW-1:0] rdData    // Registered read data.
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Two independent ports; read data always comes one edge after the address.
   always @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end

endmodule

// File: rxmf_frame_filter.v
`timescale 1ns/1ps
`include "rxmf_consts.vh"
// Notes on behaviour
// - Start on preamble sync, take the whole packet, check its CRC before deciding.
// - Two-bit mode field: 00 normal, 10 error, 01 promiscuous.
// - Normal mode needs good CRC and a legal frame type.
// - Normal beacons need source PAN equal to ours, unless ours is broadcast.
// - Normal mode: a destination PAN must be ours or broadcast.
// - Short destination must be ours or broadcast; else extended must be ours.
// - Source-only data or command frames need coordinator role and matching PAN.
// - Error mode accepts packets whatever their CRC.
// - Promiscuous mode accepts every good-CRC packet that the frame-type filter passes, no address filtering.
// - Frame-type filter: 000 all, 100 command, 010 data, 001 beacon.
// - Acknowledge-request bit five asks the transmit side for an automatic ack.
// - The ack carries the received sequence number.
// - Passing packets go to the buffer and raise the receive flag, bit three.
// - Host reads the buffer over serial port at long addresses 300 to 38F.
// - Byte zero holds frame length; FCS is followed by LQI then RSSI.
// - 256-byte dual-port buffer in two 128-byte pages, filled byte by byte through a write pointer.
// - Pointer resets on first-byte read, on the self-clearing flush, on soft reset.
// - One packet at a time; reading the first byte frees the buffer.
// - Decode inversion set blocks reception; host sets it while reading.
// - Security-enabled bit three raises the security flag, bit four.
module rxmf_frame_filter
(
   input wire clk,                       // Device clock, 125 MHz.
   input wire reset_n,                   // Synchronous reset, active low.
   input wire spiSck,                    // Serial clock from the host.
   input wire spiCsN,                    // Serial select, active low.
   input wire spiMosi,                   // Serial data from the host.
   output wire spiMiso,                  // Serial data to the host.
   output wire spiMisoOeN,               // Low while the device drives the data line.
   input wire rxSfd,                     // Pulse: demodulator found preamble sync.
   input wire rxByteValid,               // Pulse: rxByte holds the next byte.
   input wire [7:0] rxByte,              // Length byte first, then the frame.
   input wire [7:0] rxLqi,               // Link quality of the current frame.
   input wire [7:0] rxRssi,              // Signal strength of the current frame.
   input wire [15:0] panId,              // Own PAN identifier.
   input wire [15:0] shortAddress,       // Own short address.
   input wire [63:0] extendedAddress,    // Own extended address.
   output reg ackRequest_q,              // Pulse to the transmit side: send an ack.
   output reg [7:0] ackSeqNum_q          // Sequence number for that ack.
);

   localparam ST_IDLE = 6'h01;
   localparam ST_LEN = 6'h02;
   localparam ST_BODY = 6'h04;
   localparam ST_LQI = 6'h08;
   localparam ST_RSSI = 6'h10;
   localparam ST_DECIDE = 6'h20;

   reg sck1_q, sck2_q, sck3_q, cs1_q, cs2_q, mosi1_q, mosi2_q;
   reg [4:0] bitCnt_q;
   reg isLong_q;
   reg [15:0] hdr_q;
   reg [6:0] wrSh_q;
   reg [7:0] tx_q;
   reg [7:0] rxMacCtrl_q, filtFlush_q, intStatus_q, intEnable_q, bbCtrl_q;
   reg [5:0] state_q;
   reg [6:0] frameLen_q, idx_q, wrPtr_q;
   reg [15:0] crc_q, fcf_q, dstPan_q, dstShort_q, srcPan_q;
   reg [7:0] seq_q;
   reg extMatch_q, activePage_q, pending_q;
   reg [7:0] bufWrData, rdMux;
   reg accept;

   wire sckRise = sck2_q & ~sck3_q;
   wire sckFall = ~sck2_q & sck3_q;
   wire [4:0] hdrLen = isLong_q ? `RXMF_LONG_HDR : `RXMF_SHORT_HDR;
   wire [9:0] accAddr = isLong_q ? hdr_q[14:5] : {4'h0, hdr_q[6:1]};
   wire accWrite = isLong_q ? hdr_q[4] : hdr_q[0];
   wire bufSel = isLong_q && accAddr >= `RXMF_BUF_FIRST && accAddr <= `RXMF_BUF_LAST;
   wire [7:0] bufRdData;
   wire readPulse = sckFall && !cs2_q && bitCnt_q == hdrLen && !accWrite;
   wire regWrite = sckRise && !cs2_q && !isLong_q && bitCnt_q == hdrLen + 5'h07;
   wire [7:0] wrByte = {wrSh_q, mosi2_q};
   wire shortWr = regWrite && accWrite;
   wire firstRead = readPulse && bufSel && accAddr == `RXMF_BUF_FIRST;
   wire statusRead = readPulse && !isLong_q && accAddr[5:0] == `RXMF_ADDR_INT_STATUS;
   wire flush = shortWr && accAddr[5:0] == `RXMF_ADDR_FILTER_FLUSH && wrByte[`RXMF_FLUSH_BIT];
   wire software_reset_control = shortWr && accAddr[5:0] == `RXMF_ADDR_SOFT_RESET
                  && wrByte[`RXMF_SOFT_MAC_BIT];
   wire decInv = bbCtrl_q[`RXMF_DECINV_BIT];
   wire [1:0] mode = rxMacCtrl_q[`RXMF_MODE_LSB +: 2];
   wire [2:0] filt = filtFlush_q[`RXMF_FILTER_LSB +: 3];
   wire start = state_q == ST_IDLE && rxSfd && !decInv && !pending_q;
   wire bufWrEn = ((state_q == ST_LEN || state_q == ST_BODY) && rxByteValid)
                  || state_q == ST_LQI || state_q == ST_RSSI;

   // Addressing layout follows from the frame control field once it is in.
   wire [1:0] dm = fcf_q[11:10];
   wire [1:0] sm = fcf_q[15:14];
   wire [2:0] ftype = fcf_q[2:0];
   wire [6:0] dAddrOff = dm[1] ? 7'h05 : 7'h03;
   wire [6:0] dLen = dm == 2'h2 ? 7'h02 : (dm == 2'h3 ? 7'h08 : 7'h00);
   wire [6:0] sPanOff = dAddrOff + dLen;
   wire sPanPresent = sm[1] && !fcf_q[`RXMF_FCF_PANCOMP_BIT];
   wire [6:0] k = idx_q - dAddrOff;
   wire [15:0] effSrcPan = fcf_q[`RXMF_FCF_PANCOMP_BIT] ? dstPan_q : srcPan_q;

   function [15:0] crcStep;
      input [15:0] c;
      input [7:0] d;
      integer i;
      reg [15:0] r;
      begin
         r = c;
         for (i = 0; i < 8; i = i + 1)
         begin
            if (r[0] ^ d[i])
               r = (r >> 1) ^ `RXMF_CRC_POLY;
            else
               r = r >> 1;
         end
         crcStep = r;
      end
   endfunction

   // Serial pins are asynchronous to clk; the second stage feeds logic, and a third clock stage gives edge detection.
   always @(posedge clk)
   begin
      sck1_q <= spiSck;
      sck2_q <= sck1_q;
      sck3_q <= sck2_q;
      cs1_q <= spiCsN;
      cs2_q <= cs1_q;
      mosi1_q <= spiMosi;
      mosi2_q <= mosi1_q;
   end

   // Serial framing: header on rising edges, read data loaded and shifted on falling edges.
   always @(posedge clk)
   begin
      if (!reset_n || cs2_q)
      begin
         bitCnt_q <= 5'h00;
         isLong_q <= 1'b0;
         hdr_q <= 16'h0000;
         wrSh_q <= 7'h00;
         tx_q <= 8'h00;
      end
      else
      begin
         if (sckRise)
         begin
            if (bitCnt_q == 5'h00)
               isLong_q <= mosi2_q;
            if (bitCnt_q < hdrLen)
               hdr_q <= {hdr_q[14:0], mosi2_q};
            else
               wrSh_q <= {wrSh_q[5:0], mosi2_q};
            if (bitCnt_q != 5'h1f)
               bitCnt_q <= bitCnt_q + 5'h01;
         end
         if (sckFall && bitCnt_q == hdrLen)
            tx_q <= accWrite ? 8'h00 : rdMux;
         else if (sckFall && bitCnt_q > hdrLen)
            tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   assign spiMiso = tx_q[7];
   assign spiMisoOeN = cs2_q;

   // Read multiplexer; the 0x380 to 0x38F tail of the window reads as zero.
   always @*
   begin
      rdMux = 8'h00;
      if (bufSel)
         rdMux = accAddr[7] ? 8'h00 : bufRdData;
      else if (!isLong_q)
      begin
         case (accAddr[5:0])
            `RXMF_ADDR_RX_MAC_CTRL: rdMux = rxMacCtrl_q;
            `RXMF_ADDR_FILTER_FLUSH: rdMux = filtFlush_q;
            `RXMF_ADDR_INT_STATUS: rdMux = intStatus_q;
            `RXMF_ADDR_INT_ENABLE: rdMux = intEnable_q;
            `RXMF_ADDR_BB_CTRL_ONE: rdMux = bbCtrl_q;
            default: rdMux = 8'h00;
         endcase
      end
   end

   // Configuration registers; flush and soft-reset bits act once and read back as zero.
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         rxMacCtrl_q <= `RXMF_RST_RX_MAC_CTRL;
         filtFlush_q <= `RXMF_RST_FILTER_FLUSH;
         intEnable_q <= `RXMF_RST_INT_ENABLE;
         bbCtrl_q <= `RXMF_RST_BB_CTRL_ONE;
      end
      else if (shortWr)
      begin
         case (accAddr[5:0])
            `RXMF_ADDR_RX_MAC_CTRL: rxMacCtrl_q <= wrByte & `RXMF_MASK_RX_MAC_CTRL;
            `RXMF_ADDR_FILTER_FLUSH: filtFlush_q <= wrByte & `RXMF_MASK_FILTER_FLUSH;
            `RXMF_ADDR_INT_ENABLE: intEnable_q <= wrByte;
            `RXMF_ADDR_BB_CTRL_ONE: bbCtrl_q <= wrByte & `RXMF_MASK_BB_CTRL_ONE;
            default: rxMacCtrl_q <= rxMacCtrl_q;
         endcase
      end
   end

   // Acceptance: mode policy, then the frame-type filter.
   always @*
   begin
      accept = 1'b0;
      if (mode[1])
         accept = 1'b1;
      else if (mode[0])
         accept = crc_q == 16'h0000;
      else
         accept = crc_q == 16'h0000 && !ftype[2]
            && (ftype != `RXMF_TYPE_BEACON || panId == `RXMF_BROADCAST
                || effSrcPan == panId)
            && (!dm[1] || dstPan_q == panId || dstPan_q == `RXMF_BROADCAST)
            && (dm != 2'h2 || dstShort_q == shortAddress
                || dstShort_q == `RXMF_BROADCAST)
            && (dm != 2'h3 || extMatch_q)
            && (dm[1] || !sm[1]
                || (ftype != `RXMF_TYPE_DATA && ftype != `RXMF_TYPE_CMD)
                || (rxMacCtrl_q[`RXMF_PAN_COORD_BIT] && effSrcPan == panId));
      if (filt != `RXMF_FILT_ALL)
         accept = accept && ((filt[2] && ftype == `RXMF_TYPE_CMD)
            || (filt[1] && ftype == `RXMF_TYPE_DATA)
            || (filt[0] && ftype == `RXMF_TYPE_BEACON));
   end

   // Buffer write data: length, frame with FCS, then LQI and RSSI.
   always @*
   begin
      case (state_q)
         ST_LQI: bufWrData = rxLqi;
         ST_RSSI: bufWrData = rxRssi;
         default: bufWrData = rxByte;
      endcase
   end

   // Receive sequence; bytes land in the hidden page, which only becomes visible on
   // acceptance, so a rejected frame never disturbs what the host may still be reading.
   always @(posedge clk)
   begin
      if (!reset_n || software_reset_control)
      begin
         state_q <= ST_IDLE;
         frameLen_q <= 7'h00;
         idx_q <= 7'h00;
         crc_q <= 16'h0000;
         fcf_q <= 16'h0000;
         seq_q <= 8'h00;
         dstPan_q <= 16'h0000;
         dstShort_q <= 16'h0000;
         srcPan_q <= 16'h0000;
         extMatch_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (start)
               begin
                  state_q <= ST_LEN;
                  idx_q <= 7'h00;
                  crc_q <= 16'h0000;
                  fcf_q <= 16'h0000;
                  extMatch_q <= 1'b1;
               end
            end
            ST_LEN:
            begin
               if (rxByteValid)
               begin
                  frameLen_q <= rxByte[6:0];
                  state_q <= rxByte[6:0] == 7'h00 ? ST_LQI : ST_BODY;
               end
            end
            ST_BODY:
            begin
               if (rxByteValid)
               begin
                  crc_q <= crcStep(crc_q, rxByte);
                  idx_q <= idx_q + 7'h01;
                  if (idx_q == 7'h00)
                     fcf_q[7:0] <= rxByte;
                  if (idx_q == 7'h01)
                     fcf_q[15:8] <= rxByte;
                  if (idx_q == 7'h02)
                     seq_q <= rxByte;
                  if (dm[1] && idx_q == 7'h03)
                     dstPan_q[7:0] <= rxByte;
                  if (dm[1] && idx_q == 7'h04)
                     dstPan_q[15:8] <= rxByte;
                  if (idx_q >= dAddrOff && k < dLen)
                  begin
                     if (k == 7'h00)
                        dstShort_q[7:0] <= rxByte;
                     if (k == 7'h01)
                        dstShort_q[15:8] <= rxByte;
                     if (rxByte != extendedAddress[{k[2:0], 3'h0} +: 8])
                        extMatch_q <= 1'b0;
                  end
                  if (sPanPresent && idx_q == sPanOff)
                     srcPan_q[7:0] <= rxByte;
                  if (sPanPresent && idx_q == sPanOff + 7'h01)
                     srcPan_q[15:8] <= rxByte;
                  if (idx_q + 7'h01 == frameLen_q)
                     state_q <= ST_LQI;
               end
            end
            ST_LQI: state_q <= ST_RSSI;
            ST_RSSI: state_q <= ST_DECIDE;
            ST_DECIDE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Write pointer, visible page, pending packet and acknowledge request.
   // A flush in the middle of a frame restarts the pointer, so that frame comes out garbled.
   always @(posedge clk)
   begin
      if (!reset_n || software_reset_control)
      begin
         wrPtr_q <= 7'h00;
         activePage_q <= 1'b0;
         pending_q <= 1'b0;
         ackRequest_q <= 1'b0;
         ackSeqNum_q <= 8'h00;
      end
      else
      begin
         ackRequest_q <= 1'b0;
         if (start || firstRead || flush)
            wrPtr_q <= 7'h00;
         else if (bufWrEn)
            wrPtr_q <= wrPtr_q + 7'h01;
         if (firstRead)
            pending_q <= 1'b0;
         if (state_q == ST_DECIDE && accept)
         begin
            activePage_q <= ~activePage_q;
            pending_q <= 1'b1;
            ackRequest_q <= fcf_q[`RXMF_FCF_ACKREQ_BIT]
                            && !rxMacCtrl_q[`RXMF_NO_ACK_BIT];
            ackSeqNum_q <= seq_q;
         end
      end
   end

   // Interrupt status clears on read, but a new event in that cycle still sets its bit.
   always @(posedge clk)
   begin
      if (!reset_n || software_reset_control)
         intStatus_q <= 8'h00;
      else
      begin
         if (statusRead)
            intStatus_q <= 8'h00;
         if (state_q == ST_DECIDE && accept)
         begin
            intStatus_q[`RXMF_RX_IRQ_BIT] <= 1'b1;
            if (fcf_q[`RXMF_FCF_SEC_BIT])
               intStatus_q[`RXMF_SEC_IRQ_BIT] <= 1'b1;
         end
      end
   end

   rxmf_buffer #(.AW(8), .DW(8)) uBuffer
   (
      .clk(clk),
      .wrEn(bufWrEn),
      .wrAddr({~activePage_q, wrPtr_q}),
      .wrData(bufWrData),
      .rdAddr({activePage_q, accAddr[6:0]}),
      .rdData(bufRdData)
   );

endmodule

// File: rxmf_chk.sv
`timescale 1ns/1ps
module rxmf_chk
(
   input wire clk, // Clock.
   input wire reset_n, // Reset, active low.
   input wire spiSck, // Serial clock.
   input wire spiCsN, // Select, active low.
   input wire spiMosi, // Host data.
   input wire spiMiso, // Device data.
   input wire spiMisoOeN, // Data enable, active low.
   input wire rxSfd, // Frame start.
   input wire rxByteValid, // Byte strobe.
   input wire [7:0] rxByte, // Byte.
   input wire [7:0] rxLqi, // Quality.
   input wire [7:0] rxRssi, // Strength.
   input wire [15:0] panId, // Own PAN.
   input wire [15:0] shortAddress, // Own address.
   input wire [63:0] extendedAddress, // Own long address.
   input wire ackRequest_q, // Ack pulse.
   input wire [7:0] ackSeqNum_q // Ack number.
);
   logic [7:0] cnt_q, len_q, fcf_q, seq_q;
   // Follow each frame so that an ack can be tied back to the bytes behind it.
   always @(posedge clk)
   begin
      if (!reset_n || rxSfd)
         cnt_q <= 8'h00;
      else if (rxByteValid)
         cnt_q <= cnt_q + 8'h01;
      if (rxByteValid && cnt_q == 8'h00)
         len_q <= rxByte;
      if (rxByteValid && cnt_q == 8'h01)
         fcf_q <= rxByte;
      if (rxByteValid && cnt_q == 8'h03)
         seq_q <= rxByte;
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   chk_ack_pulse:
      assert property (ackRequest_q |=> !ackRequest_q) else $error("ack pulse too long");
   chk_ack_timing:
      assert property (ackRequest_q |-> $past(rxByteValid, 4)) else $error("ack off time");
   chk_frame_whole:
      assert property (ackRequest_q |-> cnt_q == len_q + 8'h01) else $error("ack mid frame");
   chk_ack_asked:
      assert property (ackRequest_q |-> fcf_q[5]) else $error("ack not asked for");
   chk_ack_seq:
      assert property (ackRequest_q |-> ackSeqNum_q == seq_q) else $error("ack number wrong");
   chk_oen_release:
      assert property ($rose(spiCsN) |-> ##[1:4] spiMisoOeN) else $error("data kept driven");
   chk_oen_drive:
      assert property ($fell(spiCsN) |-> ##[1:4] !spiMisoOeN) else $error("data not driven");
   chk_miso_idle:
      assert property (spiCsN [*5] |-> !spiMiso) else $error("data not low when idle");
   chk_miso_steady:
      assert property (spiSck [*5] |-> $stable(spiMiso)) else $error("data moved with clock high");
endmodule
bind rxmf_frame_filter rxmf_chk rxmf_chk_i (.clk(clk), .reset_n(reset_n), .spiSck(spiSck),
   .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN),
   .rxSfd(rxSfd), .rxByteValid(rxByteValid), .rxByte(rxByte), .rxLqi(rxLqi),
   .rxRssi(rxRssi), .panId(panId), .shortAddress(shortAddress),
   .extendedAddress(extendedAddress), .ackRequest_q(ackRequest_q), .ackSeqNum_q(ackSeqNum_q));

// File: rxmf_host_model.sv
`timescale 1ns/1ps
module rxmf_host_model
(
   input wire clk, // Paces the serial clock.
   input wire spiMiso, // Data from the device.
   output logic spiSck, // Serial clock, still between frames.
   output logic spiCsN, // Select, active low.
   output logic spiMosi // Data to the device.
);
   // Idle bus: select high, clock low.
   initial
   begin
      spiSck = 1'b0;
      spiCsN = 1'b1;
      spiMosi = 1'b0;
   end
   // One access per select frame, 160 ns serial period; data is taken on the rise.
   task automatic xfer(input logic lng, input logic [9:0] a, input logic w,
      input logic [7:0] wd, output logic [7:0] rd);
      logic [23:0] sh;
      int n;
      sh = lng ? {1'b1, a, w, 4'h0, wd} : {1'b0, a[5:0], w, wd, 8'h00};
      n = lng ? 24 : 16;
      rd = 8'h00;
      @(negedge clk);
      spiCsN = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         spiMosi = sh[23 - i];
         repeat (10) @(negedge clk);
         spiSck = 1'b1;
         if (i >= n - 8)
            rd = {rd[6:0], spiMiso};
         repeat (10) @(negedge clk);
         spiSck = 1'b0;
      end
      repeat (10) @(negedge clk);
      spiCsN = 1'b1;
      spiMosi = ~spiMosi; // Released line must not keep its last value.
      repeat (4) @(negedge clk);
   endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   wire spiSck, spiCsN, spiMosi, spiMiso, spiMisoOeN, ackRequest_q;
   wire [7:0] ackSeqNum_q;
   logic rxSfd = 1'b0, rxByteValid = 1'b0;
   logic [7:0] rxByte = 8'h00, rxLqi = 8'h00, rxRssi = 8'h00;
   logic [15:0] panId = 16'h0000, shortAddress = 16'h0000;
   logic [63:0] extendedAddress = 64'h0000_0000_0000_0000;
   logic [31:0] seed = 32'h0001_1108;
   logic [7:0] fr[$];
   logic [7:0] v, ackCnt = 8'h00, ackExp = 8'h00, lastLen = 8'h00;
   logic hold = 1'b0, noAck = 1'b0;
   logic [9:0] ra[8] = '{10'h000, 10'h00d, 10'h02a, 10'h031, 10'h032, 10'h039, 10'h03f, 10'h385};
   logic [2:0] fl[4] = '{3'h0, 3'h4, 3'h2, 3'h1};
   logic [2:0] ty[3] = '{3'h0, 3'h1, 3'h3};
   int nErrors = 0, totalChecks = 0;
   always #4 clk = ~clk;
   // Ack pulses are one cycle wide, so each edge counts one.
   always @(posedge clk)
      if (ackRequest_q === 1'b1)
         ackCnt <= ackCnt + 8'h01;
   rxmf_frame_filter rxmf_frame_filter_i (.clk(clk), .reset_n(reset_n), .spiSck(spiSck),
      .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN),
      .rxSfd(rxSfd), .rxByteValid(rxByteValid), .rxByte(rxByte), .rxLqi(rxLqi),
      .rxRssi(rxRssi), .panId(panId), .shortAddress(shortAddress),
      .extendedAddress(extendedAddress), .ackRequest_q(ackRequest_q), .ackSeqNum_q(ackSeqNum_q));
   // A released data line floats, so the host sees the opposite of what the pin shows.
   wire misoLine = spiMisoOeN ? ~spiMiso : spiMiso;
   rxmf_host_model rxmf_host_model_i (.clk(clk), .spiMiso(misoLine), .spiSck(spiSck),
      .spiCsN(spiCsN), .spiMosi(spiMosi));
   // Xorshift source; the fixed start keeps every run the same.
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   // Reflected frame check, bit by bit, kept apart from the design's own.
   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++)
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      return c;
   endfunction
   function automatic logic fpass(input logic [2:0] f, input logic [2:0] t);
      return f == 3'h0 || (f[2] && t == 3'h3) || (f[1] && t == 3'h1) || (f[0] && t == 3'h0);
   endfunction
   task automatic ck(input string nm, input logic [7:0] seen, input logic [7:0] want);
      totalChecks++;
      if (seen !== want)
      begin
         nErrors++;
         $display("FAIL %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      rxmf_host_model_i.xfer(a > 10'h03f, a, 1'b0, 8'h00, d);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] x;
      rxmf_host_model_i.xfer(1'b0, a, 1'b1, d, x);
   endtask
   task automatic p16(input logic [15:0] x);
      fr.push_back(x[7:0]);
      fr.push_back(x[15:8]);
   endtask
   // Sends one frame, then reads status and, unless held, length; the length read frees the buffer.
   task automatic run(input logic [15:0] fcf, input logic [15:0] pan, input logic [63:0] adr,
      input int nAdr, input logic bad, input logic acc);
      logic [15:0] c;
      int n;
      c = 16'h0000;
      fr = {fcf[7:0], fcf[15:8], rnd()};
      p16(pan);
      for (int i = 0; i < nAdr; i++)
         fr.push_back(adr[8*i +: 8]);
      if (fcf[11] && fcf[15])
         p16(16'h0042);
      n = rnd() % 6;
      repeat (n) fr.push_back(rnd());
      foreach (fr[i]) c = crc(c, fr[i]);
      if (bad)
         c = ~c;
      p16(c);
      rxLqi = rnd();
      rxRssi = rnd();
      @(negedge clk) rxSfd = 1'b1;
      @(negedge clk);
      rxSfd = 1'b0;
      rxByteValid = 1'b1;
      rxByte = 8'(fr.size());
      foreach (fr[i])
      begin
         @(negedge clk);
         rxByte = fr[i];
      end
      @(negedge clk);
      rxByteValid = 1'b0;
      repeat (12) @(negedge clk);
      if (acc && fcf[5] && !noAck)
         ackExp++;
      rd(10'h031, v);
      ck("status", v, acc ? {3'h0, fcf[3], 4'h8} : 8'h00);
      ck("acks", ackCnt, ackExp);
      rd(10'h031, v);
      ck("status again", v, 8'h00);
      if (acc)
         lastLen = 8'(fr.size());
      // A held packet stays unread, so the next frame must find the buffer taken.
      if (!hold)
      begin
         rd(10'h300, v);
         ck("length", v, lastLen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cuts a hang short.
   initial
   begin
      repeat (100000) @(posedge clk);
      nErrors++;
      test_done;
   end
   // Main sequence.
   initial
   begin
      panId = {rnd() & 8'h7f, rnd()};
      shortAddress = {rnd() & 8'h7f, rnd()};
      repeat (8) extendedAddress = {extendedAddress[55:0], rnd()};
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      foreach (ra[i])
      begin
         rd(ra[i], v);
         ck("reset value", v, 8'h00);
      end
      run(16'h8861, panId, 64'(shortAddress), 2, 1'b0, 1'b1);
      wr(10'h039, 8'h04);
      foreach (fr[i])
      begin
         rd(10'h301 + 10'(i), v);
         ck("buffer", v, fr[i]);
      end
      rd(10'h301 + 10'(fr.size()), v);
      ck("quality", v, rxLqi);
      rd(10'h302 + 10'(fr.size()), v);
      ck("strength", v, rxRssi);
      wr(10'h039, 8'h00);
      run(16'h8869, 16'hffff, 64'h0000_0000_0000_ffff, 2, 1'b0, 1'b1);
      run(16'h8861, panId, 64'(shortAddress ^ 16'h0100), 2, 1'b0, 1'b0);
      run(16'h8861, panId ^ 16'h0001, 64'(shortAddress), 2, 1'b0, 1'b0);
      run(16'h8861, panId, 64'(shortAddress), 2, 1'b1, 1'b0);
      run(16'h8864, panId, 64'(shortAddress), 2, 1'b0, 1'b0);
      run(16'h8c61, panId, extendedAddress, 8, 1'b0, 1'b1);
      run(16'h8c61, panId, extendedAddress ^ 64'h0000_0000_0000_0001, 8, 1'b0, 1'b0);
      run(16'h8000, panId, 64'h0042, 2, 1'b0, 1'b1);
      run(16'h8000, panId ^ 16'h0001, 64'h0042, 2, 1'b0, 1'b0);
      panId = 16'hffff;
      run(16'h8000, 16'h1234, 64'h0042, 2, 1'b0, 1'b1);
      panId = {rnd() & 8'h7f, rnd()};
      run(16'h8021, panId, 64'h0042, 2, 1'b0, 1'b0);
      wr(10'h000, 8'h08);
      run(16'h8021, panId, 64'h0042, 2, 1'b0, 1'b1);
      wr(10'h000, 8'h02);
      run(16'h8861, panId, 64'(shortAddress), 2, 1'b1, 1'b1);
      wr(10'h000, 8'h01);
      run(16'h8861, panId ^ 16'h0001, 64'h0001, 2, 1'b0, 1'b1);
      run(16'h8861, panId, 64'(shortAddress), 2, 1'b1, 1'b0);
      noAck = 1'b1;
      wr(10'h000, 8'h21);
      run(16'h8861, panId, 64'h0001, 2, 1'b0, 1'b1);
      noAck = 1'b0;
      wr(10'h000, 8'h01);
      foreach (fl[i])
      begin
         wr(10'h00d, {4'h0, fl[i], 1'b1});
         rd(10'h00d, v);
         ck("filter", v, {4'h0, fl[i], 1'b0});
         foreach (ty[j])
            run(16'h8860 | {13'h0000, ty[j]}, panId, 64'h0001, 2, 1'b0, fpass(fl[i], ty[j]));
      end
      wr(10'h00d, 8'h00);
      wr(10'h039, 8'h04);
      rd(10'h039, v);
      ck("inversion", v, 8'h04);
      run(16'h8861, panId, 64'(shortAddress), 2, 1'b0, 1'b0);
      wr(10'h039, 8'h00);
      wr(10'h02a, 8'h01);
      rd(10'h02a, v);
      ck("soft reset", v, 8'h00);
      rd(10'h000, v);
      ck("mode kept", v, 8'h01);
      hold = 1'b1;
      run(16'h8861, panId, 64'h0001, 2, 1'b0, 1'b1);
      hold = 1'b0;
      run(16'h8c61, panId, extendedAddress, 8, 1'b0, 1'b0);
      run(16'h8861, panId, 64'h0001, 2, 1'b0, 1'b1);
      test_done;
   end
endmodule
